// ===== core/dtor_pkg.sv
// Purpose: Constants and types for the dead-time and pin override register block.
// Assumes: Byte-wide register port; one clock clk_sys at 10 MHz; synchronous reset.
// Notes: Offsets are byte addresses on the plain register port.
// Notes on behaviour
// - One write to the both-sides alias loads low and high dead time together.
// - One write to the both-sides buffer alias loads both buffers together.
// - Low-side dead time is an eight-bit count of peripheral clock cycles.
// - High-side dead time is an eight-bit count of peripheral clock cycles.
// - Valid low buffer moves into low dead time on UPDATE, never earlier.
// - Valid high buffer moves into high dead time on UPDATE, never earlier.
// - Override enable writes take effect only while the fault flag is clear.
// - Each set override enable bit replaces that pin's port output value.
// - Override never changes pin direction; only output value is replaced.
// - Buffer valid flag sets on buffer write; transfer needs flag and no lock.
// - Fault flag sets on any masked event; cleared by writing one.
// - Pattern mode overrides dead-time insertion and uses dead-time storage as pattern.
package dtor_pkg;

    // ********************************
    // Register offsets
    // ********************************
    localparam logic [3:0] OFS_CTRL      = 4'h0;
    localparam logic [3:0] OFS_FMASK     = 4'h2;
    localparam logic [3:0] OFS_FCTRL     = 4'h3;
    localparam logic [3:0] OFS_STATUS    = 4'h4;
    localparam logic [3:0] OFS_BOTH      = 4'h6;
    localparam logic [3:0] OFS_BOTH_BUF  = 4'h7;
    localparam logic [3:0] OFS_LOW       = 4'h8;
    localparam logic [3:0] OFS_HIGH      = 4'h9;
    localparam logic [3:0] OFS_LOW_BUF   = 4'ha;
    localparam logic [3:0] OFS_HIGH_BUF  = 4'hb;
    localparam logic [3:0] OFS_OVEN      = 4'hc;
    localparam logic [3:0] OFS_IRQ_MASK  = 4'hd;

    // ********************************
    // Field positions and reset values
    // ********************************
    localparam int         BIT_LOW_VALID  = 0;
    localparam int         BIT_HIGH_VALID = 1;
    localparam int         BIT_FAULT      = 2;
    localparam logic [7:0] CTRL_MASK      = 8'h3f;
    localparam logic [7:0] FCTRL_MASK     = 8'h17;
    localparam logic [7:0] STATUS_MASK    = 8'h07;
    localparam logic [7:0] RST_BYTE       = 8'h00;

    typedef struct packed {
        logic [1:0] unused;
        logic       pattern_mode;
        logic       common_waveform_mode;
        logic [3:0] insert_enable;
    } dtor_ctrl_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dtor_bus_req_t;

endpackage : dtor_pkg

// ===== core/dtor_regs.sv
// Purpose: Dead-time counts, their double buffers, override enables and fault flag.
// Assumes: Timer supplies update and lock_update on clk_sys; events are on clk_sys.
// Notes: Status flags are write-one-to-clear; a hardware set wins over a clear.
`timescale 1ns/100ps
`default_nettype none
module dtor_regs #(
    parameter int EVENT_CHANNELS = 8,
    parameter int PINS           = 8
) (
    input  wire logic                      clk_sys,
    input  wire logic                      srst,
    input  wire dtor_pkg::dtor_bus_req_t   bus_req,
    output logic [7:0]                     rdata,
    input  wire logic                      update,
    input  wire logic                      lock_update,
    input  wire logic [EVENT_CHANNELS-1:0] events,
    input  wire logic [PINS-1:0]           port_out,
    input  wire logic [PINS-1:0]           port_dir,
    input  wire logic [PINS-1:0]           ext_wave,
    output logic [PINS-1:0]                pin_out,
    output logic [PINS-1:0]                pin_oe,
    output logic [7:0]                     dead_time_low,
    output logic [7:0]                     dead_time_high,
    output logic                           pattern_mode,
    output logic                           common_waveform_mode,
    output logic [3:0]                     insert_enable,
    output logic [7:0]                     pattern,
    output logic [7:0]                     fault_control,
    output logic                           fault_flag,
    output logic                           irq
);

    // ********************************
    // Decode
    // ********************************
    logic       wr;
    logic [3:0] a;
    logic [7:0] wd;
    assign wr = bus_req.wr;
    assign a  = bus_req.addr;
    assign wd = bus_req.wdata;

    logic w_low, w_high, w_lbuf, w_hbuf;
    assign w_low  = wr && (a == dtor_pkg::OFS_LOW  || a == dtor_pkg::OFS_BOTH);
    assign w_high = wr && (a == dtor_pkg::OFS_HIGH || a == dtor_pkg::OFS_BOTH);
    assign w_lbuf = wr && (a == dtor_pkg::OFS_LOW_BUF  || a == dtor_pkg::OFS_BOTH_BUF);
    assign w_hbuf = wr && (a == dtor_pkg::OFS_HIGH_BUF || a == dtor_pkg::OFS_BOTH_BUF);

    logic xfer;
    assign xfer = update && !lock_update;

    // ********************************
    // Registers
    // ********************************
    dtor_pkg::dtor_ctrl_t ctrl_r;
    logic [7:0] fmask_r, fctrl_r, low_r, high_r, lbuf_r, hbuf_r, oven_r, imask_r;
    logic       lval_r, hval_r, fault_r;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_r  <= dtor_pkg::RST_BYTE;
            fmask_r <= dtor_pkg::RST_BYTE;
            fctrl_r <= dtor_pkg::RST_BYTE;
            imask_r <= dtor_pkg::RST_BYTE;
        end else if (wr) begin
            if (a == dtor_pkg::OFS_CTRL) begin
                ctrl_r <= wd & dtor_pkg::CTRL_MASK;
            end else if (a == dtor_pkg::OFS_FMASK) begin
                fmask_r <= wd;
            end else if (a == dtor_pkg::OFS_FCTRL) begin
                fctrl_r <= wd & dtor_pkg::FCTRL_MASK;
            end else if (a == dtor_pkg::OFS_IRQ_MASK) begin
                imask_r <= wd & dtor_pkg::STATUS_MASK;
            end
        end
    end

    // Buffer transfer takes priority over a direct write in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            low_r <= dtor_pkg::RST_BYTE;
        end else if (xfer && lval_r) begin
            low_r <= lbuf_r;
        end else if (w_low) begin
            low_r <= wd;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            high_r <= dtor_pkg::RST_BYTE;
        end else if (xfer && hval_r) begin
            high_r <= hbuf_r;
        end else if (w_high) begin
            high_r <= wd;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lbuf_r <= dtor_pkg::RST_BYTE;
            hbuf_r <= dtor_pkg::RST_BYTE;
        end else begin
            if (w_lbuf) begin
                lbuf_r <= wd;
            end
            if (w_hbuf) begin
                hbuf_r <= wd;
            end
        end
    end

    // A buffer write in the update cycle stays pending for the next update.
    logic st_wr;
    assign st_wr = wr && a == dtor_pkg::OFS_STATUS;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lval_r <= 1'b0;
            hval_r <= 1'b0;
        end else begin
            if (w_lbuf) begin
                lval_r <= 1'b1;
            end else if (xfer || (st_wr && wd[dtor_pkg::BIT_LOW_VALID])) begin
                lval_r <= 1'b0;
            end
            if (w_hbuf) begin
                hval_r <= 1'b1;
            end else if (xfer || (st_wr && wd[dtor_pkg::BIT_HIGH_VALID])) begin
                hval_r <= 1'b0;
            end
        end
    end

    logic fault_evt;
    assign fault_evt = |(events & fmask_r[EVENT_CHANNELS-1:0]);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fault_r <= 1'b0;
        end else if (fault_evt) begin
            fault_r <= 1'b1;
        end else if (st_wr && wd[dtor_pkg::BIT_FAULT]) begin
            fault_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            oven_r <= dtor_pkg::RST_BYTE;
        end else if (wr && a == dtor_pkg::OFS_OVEN && !fault_r) begin
            oven_r <= wd;
        end
    end

    // ********************************
    // Pins
    // ********************************
    // Direction comes straight from the port, so software must still set pins as outputs.
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    pin_out[g] <= 1'b0;
                end else begin
                    pin_out[g] <= oven_r[g] ? ext_wave[g] : port_out[g];
                end
            end
            assign pin_oe[g] = port_dir[g];
        end
    endgenerate

    // ********************************
    // Read port and outputs
    // ********************************
    logic [7:0] status;
    assign status = {5'h00, fault_r, hval_r, lval_r};

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata <= dtor_pkg::RST_BYTE;
        end else if (bus_req.rd) begin
            if (a == dtor_pkg::OFS_CTRL) begin
                rdata <= ctrl_r;
            end else if (a == dtor_pkg::OFS_FMASK) begin
                rdata <= fmask_r;
            end else if (a == dtor_pkg::OFS_FCTRL) begin
                rdata <= fctrl_r;
            end else if (a == dtor_pkg::OFS_STATUS) begin
                rdata <= status;
            end else if (a == dtor_pkg::OFS_BOTH || a == dtor_pkg::OFS_LOW) begin
                rdata <= low_r;
            end else if (a == dtor_pkg::OFS_BOTH_BUF || a == dtor_pkg::OFS_LOW_BUF) begin
                rdata <= lbuf_r;
            end else if (a == dtor_pkg::OFS_HIGH) begin
                rdata <= high_r;
            end else if (a == dtor_pkg::OFS_HIGH_BUF) begin
                rdata <= hbuf_r;
            end else if (a == dtor_pkg::OFS_OVEN) begin
                rdata <= oven_r;
            end else if (a == dtor_pkg::OFS_IRQ_MASK) begin
                rdata <= imask_r;
            end else begin
                rdata <= dtor_pkg::RST_BYTE;
            end
        end else begin
            rdata <= dtor_pkg::RST_BYTE;
        end
    end

    // Pattern mode reuses the low-side storage as the pin pattern and disables insertion.
    assign pattern_mode         = ctrl_r.pattern_mode;
    assign common_waveform_mode = ctrl_r.common_waveform_mode;
    assign insert_enable        = ctrl_r.pattern_mode ? 4'h0 : ctrl_r.insert_enable;
    assign pattern              = ctrl_r.pattern_mode ? low_r : 8'h00;
    assign dead_time_low        = low_r;
    assign dead_time_high       = high_r;
    assign fault_control        = fctrl_r;
    assign fault_flag           = fault_r;
    assign irq                  = |(status & imask_r);

endmodule : dtor_regs
`default_nettype wire

// ===== test/dtor_regs_properties.sv
// Purpose: Port-level checks of the dead-time and override register block.
// Assumes: One clock clk_sys and synchronous active-high srst.
// Notes: Override enables are internal, so their lock is checked by the bench.
`timescale 1ns/100ps
`default_nettype none
module dtor_regs_properties (
    input wire logic                    clk_sys,
    input wire logic                    srst,
    input wire dtor_pkg::dtor_bus_req_t bus_req,
    input wire logic [7:0]              rdata,
    input wire logic                    update,
    input wire logic                    lock_update,
    input wire logic [7:0]              port_out,
    input wire logic [7:0]              port_dir,
    input wire logic [7:0]              ext_wave,
    input wire logic [7:0]              pin_out,
    input wire logic [7:0]              pin_oe,
    input wire logic [7:0]              dead_time_low,
    input wire logic [7:0]              dead_time_high,
    input wire logic                    pattern_mode,
    input wire logic [3:0]              insert_enable,
    input wire logic [7:0]              pattern,
    input wire logic                    fault_flag
);
    logic wr_lo;
    logic wr_hi;
    assign wr_lo = bus_req.wr && (bus_req.addr == dtor_pkg::OFS_BOTH || bus_req.addr == dtor_pkg::OFS_LOW);
    assign wr_hi = bus_req.wr && (bus_req.addr == dtor_pkg::OFS_BOTH || bus_req.addr == dtor_pkg::OFS_HIGH);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_both_alias: assert property (bus_req.wr && bus_req.addr == dtor_pkg::OFS_BOTH && !update |=>
        dead_time_low == $past(bus_req.wdata) && dead_time_high == $past(bus_req.wdata)) else $error("alias");
    a_low_hold: assert property (!update && !wr_lo |=> $stable(dead_time_low)) else $error("low moved");
    a_high_hold: assert property (!update && !wr_hi |=> $stable(dead_time_high)) else $error("high moved");
    a_lock_hold: assert property (update && lock_update && !bus_req.wr |=>
        $stable(dead_time_low) && $stable(dead_time_high)) else $error("locked update moved");
    a_read_low: assert property (bus_req.rd && bus_req.addr == dtor_pkg::OFS_LOW |=>
        rdata == $past(dead_time_low)) else $error("low read");
    a_read_high: assert property (bus_req.rd && bus_req.addr == dtor_pkg::OFS_HIGH |=>
        rdata == $past(dead_time_high)) else $error("high read");
    a_pin_dir: assert property (pin_oe == port_dir) else $error("direction touched");
    a_pin_same: assert property (port_out == ext_wave |=> pin_out == $past(port_out)) else $error("pin value");
    a_fault_sticky: assert property (fault_flag && !(bus_req.wr && bus_req.addr == dtor_pkg::OFS_STATUS
        && bus_req.wdata[dtor_pkg::BIT_FAULT]) |=> fault_flag) else $error("fault flag lost");
    a_pattern_copy: assert property (pattern_mode |-> pattern == dead_time_low
        && insert_enable == 4'h0) else $error("pattern");
    cover property (update && !lock_update);
    cover property ($rose(fault_flag));
    cover property (bus_req.wr && bus_req.addr == dtor_pkg::OFS_OVEN && fault_flag);
endmodule : dtor_regs_properties
bind dtor_regs dtor_regs_properties u_props (.clk_sys, .srst, .bus_req, .rdata, .update, .lock_update,
    .port_out, .port_dir, .ext_wave, .pin_out, .pin_oe, .dead_time_low, .dead_time_high, .pattern_mode,
    .insert_enable, .pattern, .fault_flag);
`default_nettype wire

// ===== test/dtor_timer_model.sv
// Purpose: Timer side that raises UPDATE and holds the lock-update level.
// Assumes: Requests come from the bench; delay 1 to 8 cycles.
// Notes: A variable delay makes the timer answer promptly or slowly.
`timescale 1ns/100ps
`default_nettype none
module dtor_timer_model (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       req,
    input  wire logic [3:0] dly,
    input  wire logic       lock_req,
    output logic            update,
    output logic            lock_update
);
    logic [3:0] cnt_r;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_r <= 4'h0;
            update <= 1'b0;
            lock_update <= 1'b0;
        end else begin
            lock_update <= lock_req;
            update <= (cnt_r == 4'h1);
            cnt_r <= req ? dly : (cnt_r != 4'h0 ? cnt_r - 4'h1 : 4'h0);
        end
    end
endmodule : dtor_timer_model
`default_nettype wire

// ===== test/tb.sv
// Purpose: Self-checking bench of the dead-time and override register block.
// Assumes: Seeded random stimulus with hand-picked corner cases.
// Notes: Expected values come from bench variables, never from outputs.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_sys, srst, req, lock_req, update, lock_update, fault_flag, irq, pattern_mode, cwm;
    logic [7:0] fctl;
    logic [3:0] dly, insert_enable;
    logic [7:0] rdata, events, port_out, port_dir, ext_wave, pin_out, pin_oe, dlo, dhi, pattern, got, d, b, e, m;
    dtor_pkg::dtor_bus_req_t bus_req;
    integer seed, bad_count, checks, i;
    dtor_timer_model u_dtor_timer_model (.clk_sys, .srst, .req, .dly, .lock_req, .update, .lock_update);
    dtor_regs u_dtor_regs (.clk_sys, .srst, .bus_req, .rdata, .update, .lock_update, .events, .port_out,
        .port_dir, .ext_wave, .pin_out, .pin_oe, .dead_time_low(dlo), .dead_time_high(dhi), .pattern_mode,
        .common_waveform_mode(cwm), .insert_enable, .pattern, .fault_control(fctl), .fault_flag, .irq);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] mix(input logic [7:0] en, input logic [7:0] po, input logic [7:0] ew);
        return (ew & en) | (po & ~en);
    endfunction : mix
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        checks++;
        if (g !== x) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys) bus_req <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_sys) bus_req.wr <= 1'b0;
        @(negedge clk_sys);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys) bus_req.rd <= 1'b0;
        @(negedge clk_sys) got = rdata;
    endtask : rd
    task automatic upd(input logic lk);
        @(posedge clk_sys) {req, lock_req, dly} <= {2'b11 & {1'b1, lk}, 4'h1 + 4'($unsigned($random(seed)) % 8)};
        @(posedge clk_sys) req <= 1'b0;
        for (i = 0; i < 20 && update !== 1'b1; i++) @(negedge clk_sys);
        if (update !== 1'b1) begin
            bad_count++;
            test_done;
        end
        @(negedge clk_sys);
    endtask : upd
    task automatic evt(input logic [7:0] v);
        @(posedge clk_sys) events <= v;
        @(posedge clk_sys) events <= 8'h00;
        @(negedge clk_sys);
    endtask : evt
    initial begin
        seed = 32'hafb8;
        {bad_count, checks} = 0;
        {srst, req, lock_req, dly, events, bus_req} = {1'b1, 2'b00, 4'h1, 8'h00, 14'h0};
        {port_out, port_dir, ext_wave} = 24'h0;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            rd(4'(k));
            chk(got, 8'h00);
        end
        d = $random(seed);
        wr(dtor_pkg::OFS_BOTH, d);
        rd(dtor_pkg::OFS_LOW);
        chk(got, d);
        rd(dtor_pkg::OFS_HIGH);
        chk(got, d);
        b = $random(seed);
        wr(dtor_pkg::OFS_BOTH_BUF, b);
        rd(dtor_pkg::OFS_STATUS);
        chk(got, 8'h03);
        chk(dlo, d);
        upd(1'b1);
        chk(dhi, d);
        upd(1'b0);
        chk(dlo, b);
        chk(dhi, b);
        rd(dtor_pkg::OFS_STATUS);
        chk(got, 8'h00);
        e = $random(seed);
        wr(dtor_pkg::OFS_LOW_BUF, e);
        upd(1'b0);
        chk(dlo, e);
        chk(dhi, b);
        wr(dtor_pkg::OFS_LOW, d);
        upd(1'b0);
        chk(dlo, d);
        m = $random(seed);
        wr(dtor_pkg::OFS_OVEN, m);
        @(posedge clk_sys) {port_out, port_dir, ext_wave} <= {8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk(pin_out, mix(m, port_out, ext_wave));
        chk(pin_oe, port_dir);
        wr(dtor_pkg::OFS_FMASK, 8'h01);
        evt(8'h02);
        chk({7'h0, fault_flag}, 8'h00);
        evt(8'h01);
        chk({7'h0, fault_flag}, 8'h01);
        chk({7'h0, irq}, 8'h00);
        wr(dtor_pkg::OFS_OVEN, ~m);
        chk(pin_out, mix(m, port_out, ext_wave));
        wr(dtor_pkg::OFS_IRQ_MASK, 8'h04);
        chk({7'h0, irq}, 8'h01);
        wr(dtor_pkg::OFS_STATUS, 8'h04);
        chk({6'h0, irq, fault_flag}, 8'h00);
        wr(dtor_pkg::OFS_OVEN, ~m);
        @(negedge clk_sys);
        chk(pin_out, mix(~m, port_out, ext_wave));
        wr(dtor_pkg::OFS_CTRL, 8'h2f);
        chk(pattern, d);
        chk({4'h0, insert_enable}, 8'h00);
        chk({7'h0, cwm}, 8'h00);
        wr(dtor_pkg::OFS_CTRL, 8'h1a);
        chk(pattern, 8'h00);
        chk({4'h0, insert_enable}, 8'h0a);
        chk({7'h0, cwm}, 8'h01);
        wr(dtor_pkg::OFS_FCTRL, 8'hff);
        chk(fctl, 8'h17);
        test_done;
    end
endmodule : tb
`default_nettype wire
